//--- src/tmseq_consts.vh
// constants for the 16-bit timer mode sequencer
// assumes inclusion by the sequencer module only
`ifndef TMSEQ_CONSTS_VH
`define TMSEQ_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TMSEQ_ADDR_CTRL    4'h0
`define TMSEQ_ADDR_COUNT   4'h1
`define TMSEQ_ADDR_CMPA    4'h2
`define TMSEQ_ADDR_CMPB    4'h3
`define TMSEQ_ADDR_CAPTOP  4'h4
`define TMSEQ_ADDR_FLAGS   4'h5
`define TMSEQ_ADDR_CMPABUF 4'h6

// ----------------------------------------
// control field positions
// ----------------------------------------
`define TMSEQ_CTRL_WGM_LO  0
`define TMSEQ_CTRL_CSEL_LO 4
`define TMSEQ_CTRL_COMA_LO 8
`define TMSEQ_CTRL_COMB_LO 10
`define TMSEQ_CTRL_DIRA    12
`define TMSEQ_CTRL_DIRB    13

// ----------------------------------------
// flag positions
// ----------------------------------------
`define TMSEQ_FLAG_OVF     0
`define TMSEQ_FLAG_CMPA    1
`define TMSEQ_FLAG_CMPB    2
`define TMSEQ_FLAG_CAP     3

// ----------------------------------------
// reset values and fixed tops
// ----------------------------------------
`define TMSEQ_RST_CTRL     16'h0000
`define TMSEQ_RST_WORD     16'h0000
`define TMSEQ_MAX          16'hffff
`define TMSEQ_TOP8         16'h00ff
`define TMSEQ_TOP9         16'h01ff
`define TMSEQ_TOP10        16'h03ff

// ----------------------------------------
// prescaler terminal counts (factor minus one)
// ----------------------------------------
`define TMSEQ_DIV8         10'h007
`define TMSEQ_DIV64        10'h03f
`define TMSEQ_DIV256       10'h0ff
`define TMSEQ_DIV1024      10'h3ff

`endif

//--- src/tmseq_timer.v
// 16-bit timer counting and waveform-mode sequencer with two compare channels
// assumes a synchronous single-clock register port; compare pins are driven with enables
//
// Overview of operation
// R1: mode field picks count sequence; output action never changes stepping.
// R2: normal mode counts up always, no clears, wraps ffff to 0000.
// R3: normal mode sets overflow in the cycle the count becomes zero.
// R4: overflow flag is hardware-set only; cleared by service or software write; here only the software write clears it, service is ignored.
// R5: normal mode accepts counter writes at any time.
// R6: timer tick is clock divided by 1, 8, 64, 256 or 1024.
// R7: mode 4 clears on compare A match, mode 12 on capture-top match.
// R8: clear-on-match top acts immediately; top below count wraps through ffff.
// R9: clear-on-match sets compare A or capture flag on reaching top.
// R10: action 1 in clear-on-match toggles output A; pin needs direction bit.
// R11: clear-on-match sets overflow when count rolls from ffff to zero.
// R12: modes 5,6,7,14,15 are fast pwm: count_floor to top, then restart.
// R13: pwm top 00ff/01ff/03ff, capture-top or compare A; clear next tick.
// R14: register-defined top supports 0003 up to full 16 bits.
// R15: non-inverting sets on match, clears at top-to-count_floor; inverting opposite.
// R16: pwm action 2 non-inverted, action 3 inverted.
// R17: pwm sets overflow at top, plus compare A or capture flag if top register.
// R18: fixed top masks written compare bits above the resolution.
// R19: pwm compare A writes go to buffer, loaded at top with overflow.
// R20: capture-top is unbuffered; below-count write wraps through ffff.
// R21: compare at count_floor gives spike per top+1; at top gives constant level.
// R22: pwm action 1 toggles A only in mode 15.
// R23: software keeps new top at or above every compare value.
// R24: compare buffering only in pwm; otherwise writes go straight in.
// R25: counter write suppresses compare matches on the next tick, even stopped.
// R26: action 0 leaves internal compare output unchanged in every mode.
//
// The register addresses and strobed register access were decided locally.
`default_nettype none
`include "tmseq_consts.vh"

module tmseq_timer #(
  parameter WIDTH = 16
) (
  input  wire             CLK,
  input  wire             ARST_N,
  input  wire [3:0]       ADDR,
  input  wire [WIDTH-1:0] WDATA,
  input  wire             WR,
  input  wire             RD,
  output reg  [WIDTH-1:0] RDATA,
  input  wire [1:0]       CLR_SERVICE,
  output wire [1:0]       COMPARE_OUTPUT,
  output wire [1:0]       COMPARE_OUTPUT_OE
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [WIDTH-1:0] ctrl;
  reg  [WIDTH-1:0] count_value;
  wire [WIDTH-1:0] compare_value [0:1];
  reg  [WIDTH-1:0] compare_a_buf;
  reg  [WIDTH-1:0] capture_top_value;
  reg              overflow_flag;
  wire [1:0]       compare_flag;
  reg              capture_flag;
  wire [1:0]       compare_output;
  reg              block_match;
  reg  [9:0]       prescale;

  wire [3:0] waveform_select = ctrl[`TMSEQ_CTRL_WGM_LO+3:`TMSEQ_CTRL_WGM_LO];
  wire [2:0] clock_select    = ctrl[`TMSEQ_CTRL_CSEL_LO+2:`TMSEQ_CTRL_CSEL_LO];
  wire [1:0] pin_direction_bit = {ctrl[`TMSEQ_CTRL_DIRB], ctrl[`TMSEQ_CTRL_DIRA]};
  wire [1:0] output_action_select [0:1];
  assign output_action_select[0] = ctrl[`TMSEQ_CTRL_COMA_LO+1:`TMSEQ_CTRL_COMA_LO];
  assign output_action_select[1] = ctrl[`TMSEQ_CTRL_COMB_LO+1:`TMSEQ_CTRL_COMB_LO];

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  reg tick;
  always @* begin
    case (clock_select)
      3'h1:    tick = 1'b1;
      3'h2:    tick = ((prescale & `TMSEQ_DIV8) == `TMSEQ_DIV8);     // R6
      3'h3:    tick = ((prescale & `TMSEQ_DIV64) == `TMSEQ_DIV64);   // R6
      3'h4:    tick = ((prescale & `TMSEQ_DIV256) == `TMSEQ_DIV256); // R6
      3'h5:    tick = (prescale == `TMSEQ_DIV1024);        // R6
      default: tick = 1'b0;
    endcase
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prescale <= 10'h000;
    end else if (clock_select == 3'h0) begin
      prescale <= 10'h000;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire mode_normal = (waveform_select == 4'h0);
  wire clear_on_match_mode = (waveform_select == 4'h4) || (waveform_select == 4'hc);   // R7
  wire mode_fast = (waveform_select == 4'h5) || (waveform_select == 4'h6) ||
                   (waveform_select == 4'h7) || (waveform_select == 4'he) ||
                   (waveform_select == 4'hf);                                        // R12
  wire top_is_cmpa = (waveform_select == 4'h4) || (waveform_select == 4'hf);
  wire top_is_cap  = (waveform_select == 4'hc) || (waveform_select == 4'he);

  reg [WIDTH-1:0] top_value;
  always @* begin
    case (waveform_select)
      4'h5:    top_value = `TMSEQ_TOP8;                  // R13
      4'h6:    top_value = `TMSEQ_TOP9;                  // R13
      4'h7:    top_value = `TMSEQ_TOP10;                 // R13
      4'h4:    top_value = compare_value[0];             // R7
      4'hf:    top_value = compare_value[0];             // R13 R14
      4'hc:    top_value = capture_top_value;            // R7 R20
      4'he:    top_value = capture_top_value;            // R13 R14 R20
      default: top_value = `TMSEQ_MAX;                   // R2
    endcase
  end

  // R18: mask for fixed tops
  wire [WIDTH-1:0] write_mask = (waveform_select == 4'h5 || waveform_select == 4'h6 ||
                                 waveform_select == 4'h7) ? top_value : `TMSEQ_MAX;

  // top compare is exact equality so a top below the count is missed
  wire at_top  = (mode_fast || clear_on_match_mode) && (count_value == top_value); // R8 R20
  wire at_max  = (count_value == `TMSEQ_MAX);
  wire step    = tick;
  wire matches_live = !block_match;                      // R25
  wire count_wr = WR && (ADDR == `TMSEQ_ADDR_COUNT);

  wire [WIDTH-1:0] next_count = at_top ? `TMSEQ_RST_WORD : count_value + 16'h0001; // R2 R13 R1
  wire ovf_event = step && (mode_fast ? at_top : at_max);                        // R3 R11 R17
  wire top_event = step && at_top && matches_live;                                // R9 R17

  // ----------------------------------------
  // counter and match blocking
  // ----------------------------------------
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      count_value <= `TMSEQ_RST_WORD;
      block_match <= 1'b0;
    end else begin
      if (count_wr) begin
        count_value <= WDATA;                            // R5
      end else if (step) begin
        count_value <= next_count;
      end
      if (count_wr) begin
        block_match <= 1'b1;                             // R25
      end else if (step) begin
        block_match <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // compare channels, outputs and flags
  // ----------------------------------------
  wire [1:0] cmp_event;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
      wire hit = step && matches_live && (count_value == compare_value[gi]);
      wire wr_hit = WR && (ADDR == (gi == 0 ? `TMSEQ_ADDR_CMPA : `TMSEQ_ADDR_CMPB));
      assign cmp_event[gi] = hit;
      reg             out_q;
      reg [WIDTH-1:0] cmp_q;
      reg             flag_q;
      assign compare_output[gi] = out_q;
      assign compare_value[gi]  = cmp_q;
      assign compare_flag[gi]   = flag_q;
      reg next_out;
      always @* begin
        next_out = compare_output[gi];
        if (mode_fast) begin
          case (output_action_select[gi])
            2'h1: if (hit && gi == 0 && waveform_select == 4'hf) next_out = ~compare_output[gi]; // R22
            2'h2: begin
              if (step && at_top) next_out = 1'b0;       // R15 R16
              if (hit) next_out = 1'b1;                  // R15 R21
            end
            2'h3: begin
              if (step && at_top) next_out = 1'b1;       // R15 R16
              if (hit) next_out = 1'b0;                  // R15 R21
            end
            default: next_out = compare_output[gi];      // R26
          endcase
        end else begin
          case (output_action_select[gi])
            2'h1: if (hit) next_out = ~compare_output[gi]; // R10
            2'h2: if (hit) next_out = 1'b0;
            2'h3: if (hit) next_out = 1'b1;
            default: next_out = compare_output[gi];      // R26
          endcase
        end
      end
      always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          out_q  <= 1'b0;
          cmp_q  <= `TMSEQ_RST_WORD;
          flag_q <= 1'b0;
        end else begin
          out_q <= next_out;
          if (gi == 0 && mode_fast && step && at_top) begin
            cmp_q <= compare_a_buf;                      // R19
          end else if (wr_hit && !(gi == 0 && mode_fast)) begin
            cmp_q <= WDATA & write_mask;                 // R24 R18
          end
          if (hit || (gi == 0 && top_is_cmpa && top_event)) begin
            flag_q <= 1'b1;                              // R9 R17
          end else if ((WR && ADDR == `TMSEQ_ADDR_FLAGS && WDATA[`TMSEQ_FLAG_CMPA + gi]) ||
                       CLR_SERVICE[gi]) begin
            flag_q <= 1'b0;
          end
        end
      end
      assign COMPARE_OUTPUT[gi]    = compare_output[gi] & pin_direction_bit[gi]; // R10
      assign COMPARE_OUTPUT_OE[gi] = pin_direction_bit[gi] &&
                                     (output_action_select[gi] != 2'h0);
    end
  endgenerate

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl              <= `TMSEQ_RST_CTRL;
      compare_a_buf     <= `TMSEQ_RST_WORD;
      capture_top_value <= `TMSEQ_RST_WORD;
      overflow_flag     <= 1'b0;
      capture_flag      <= 1'b0;
    end else begin
      if (WR && ADDR == `TMSEQ_ADDR_CTRL) begin
        ctrl <= WDATA;                                   // R1
      end
      if (WR && ADDR == `TMSEQ_ADDR_CMPA) begin
        compare_a_buf <= WDATA & write_mask;             // R19 R18
      end
      if (WR && ADDR == `TMSEQ_ADDR_CAPTOP) begin
        capture_top_value <= WDATA;                      // R20
      end
      if (ovf_event) begin
        overflow_flag <= 1'b1;                           // R4
      end else if ((WR && ADDR == `TMSEQ_ADDR_FLAGS && WDATA[`TMSEQ_FLAG_OVF]) || CLR_SERVICE[0] && 1'b0) begin
        overflow_flag <= 1'b0;                           // R4
      end
      if (top_is_cap && top_event) begin
        capture_flag <= 1'b1;                            // R9 R17
      end else if (WR && ADDR == `TMSEQ_ADDR_FLAGS && WDATA[`TMSEQ_FLAG_CAP]) begin
        capture_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= `TMSEQ_RST_WORD;
    end else if (RD) begin
      case (ADDR)
        `TMSEQ_ADDR_CTRL:    RDATA <= ctrl;
        `TMSEQ_ADDR_COUNT:   RDATA <= count_value;
        `TMSEQ_ADDR_CMPA:    RDATA <= compare_value[0];
        `TMSEQ_ADDR_CMPB:    RDATA <= compare_value[1];
        `TMSEQ_ADDR_CAPTOP:  RDATA <= capture_top_value;
        `TMSEQ_ADDR_FLAGS:   RDATA <= {12'h000, capture_flag, compare_flag, overflow_flag};
        `TMSEQ_ADDR_CMPABUF: RDATA <= compare_a_buf;
        default:             RDATA <= `TMSEQ_RST_WORD;
      endcase
    end else begin
      RDATA <= `TMSEQ_RST_WORD;
    end
  end

endmodule // tmseq_timer
`default_nettype wire

//--- tb/tmseq_timer_assertions.sv
// port checker for the timer sequencer
// assumes it is bound onto tmseq_timer
`default_nettype none
module tmseq_chk #(
  parameter WIDTH = 16
) (
  input wire logic             CLK,
  input wire logic             ARST_N,
  input wire logic [3:0]       ADDR,
  input wire logic [WIDTH-1:0] WDATA,
  input wire logic             WR,
  input wire logic             RD,
  input wire logic [WIDTH-1:0] RDATA,
  input wire logic [1:0]       CLR_SERVICE,
  input wire logic [1:0]       COMPARE_OUTPUT,
  input wire logic [1:0]       COMPARE_OUTPUT_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // shadow of the control word
  // ----------------------------------------
  logic [WIDTH-1:0] sh;
  logic             wc;
  assign wc = WR && ADDR == 4'h0;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) sh <= 16'h0000;
    else if (wc) sh <= WDATA;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_quiet;
    !wc;
  endsequence
  property p_oe;
    COMPARE_OUTPUT_OE == {sh[13] && sh[11:10] != 2'h0, sh[12] && sh[9:8] != 2'h0};
  endproperty
  property p_pin;
    (COMPARE_OUTPUT & ~sh[13:12]) == 2'h0;
  endproperty
  property p_act0a;
    (sh[9:8] == 2'h0) and s_quiet |=> $stable(COMPARE_OUTPUT[0]);
  endproperty
  property p_act0b;
    (sh[11:10] == 2'h0) and s_quiet |=> $stable(COMPARE_OUTPUT[1]);
  endproperty
  property p_stop;
    (sh[6:4] == 3'h0) and s_quiet |=> $stable(COMPARE_OUTPUT);
  endproperty
  property p_rd_idle;
    !RD |=> RDATA == 16'h0000;
  endproperty
  property p_unmapped;
    RD && ADDR > 4'h6 |=> RDATA == 16'h0000;
  endproperty
  property p_rd_ctrl;
    RD && ADDR == 4'h0 |=> RDATA == $past(sh);
  endproperty
  a_oe: assert property (p_oe) else $error("enable mismatch");
  a_pin: assert property (p_pin) else $error("pin driven without direction");
  a_act0a: assert property (p_act0a) else $error("output a moved with action 0");
  a_act0b: assert property (p_act0b) else $error("output b moved with action 0");
  a_stop: assert property (p_stop) else $error("output moved while stopped");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
endmodule // tmseq_chk
bind tmseq_timer tmseq_chk #(.WIDTH(WIDTH)) i_chk (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .CLR_SERVICE(CLR_SERVICE), .COMPARE_OUTPUT(COMPARE_OUTPUT),
  .COMPARE_OUTPUT_OE(COMPARE_OUTPUT_OE));
`default_nettype wire

//--- tb/tmseq_load.sv
// load on the two compare pins, measuring high time and edges of pin A only
// assumes pins released by the timer are pulled low
`default_nettype none
module tmseq_load (
  input wire logic         CLK,
  input wire logic         CLR,
  input wire logic [1:0]   PIN,
  input wire logic [1:0]   OE,
  output var logic [15:0]  HIGH_A,
  output var logic [15:0]  EDGES
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] lvl;
  logic       last;
  assign lvl = OE & PIN;
  always @(posedge CLK) begin
    last <= lvl[0];
    HIGH_A <= CLR ? 16'h0000 : HIGH_A + {15'h0000, lvl[0]};
    EDGES <= CLR ? 16'h0000 : EDGES + {15'h0000, lvl[0] != last};
  end
endmodule // tmseq_load
`default_nettype wire

//--- tb/timer16_mode_sequencer_tb.sv
// testbench for the timer sequencer and its pin load
// assumes the checker is bound in by its own file
`default_nettype none
module timer16_mode_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, arst_n = 1'b0, wrs = 1'b0, rds = 1'b0, clr = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [15:0] wd = 16'h0000, rdata, high_a, edges, v;
  logic [1:0]  svc = 2'h0, pin, oe;
  int          error_cnt = 0, checks_done = 0;
  always #20 clk = ~clk;
  tmseq_timer i_dut (.CLK(clk), .ARST_N(arst_n), .ADDR(adr), .WDATA(wd), .WR(wrs), .RD(rds), .RDATA(rdata),
    .CLR_SERVICE(svc), .COMPARE_OUTPUT(pin), .COMPARE_OUTPUT_OE(oe));
  tmseq_load i_load (.CLK(clk), .CLR(clr), .PIN(pin), .OE(oe), .HIGH_A(high_a), .EDGES(edges));
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk); adr <= a; wd <= d; wrs <= 1'b1;
    @(posedge clk); wrs <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk); adr <= a; rds <= 1'b1;
    @(posedge clk); rds <= 1'b0;
    @(negedge clk); v = rdata;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic rng(input logic [15:0] s, input logic [15:0] lo, input logic [15:0] hi);
    chk({15'h0000, s >= lo && s <= hi}, 16'h0001);
  endtask
  task automatic run(input int n);
    @(posedge clk); clr <= 1'b1;
    @(posedge clk); clr <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_normal();
    wr(4'h0, 16'h0000); wr(4'h1, 16'hfffe); rd(4'h1); chk(v, 16'hfffe);
    wr(4'h5, 16'h000f); wr(4'h0, 16'h0010); repeat (10) @(posedge clk); wr(4'h0, 16'h0000);
    rd(4'h1); rng(v, 16'h0005, 16'h000e);
    rd(4'h5); chk(v & 16'h0001, 16'h0001);
    wr(4'h5, 16'h0001); rd(4'h5); chk(v & 16'h0001, 16'h0000);
  endtask
  task automatic t_presc();
    int f[5] = '{1, 8, 64, 256, 1024};
    for (int i = 0; i < 5; i++) begin
      wr(4'h1, 16'h0000); wr(4'h0, 16'((i + 1) << 4)); repeat (f[i] * 4) @(posedge clk); wr(4'h0, 16'h0000);
      rd(4'h1); rng(v, 16'h0003, 16'h0007);
    end
  endtask
  task automatic t_ctc();
    wr(4'h1, 16'h0000); wr(4'h2, 16'h0009); wr(4'h5, 16'h000f); wr(4'h0, 16'h1114);
    run(200); rng(edges, 16'd19, 16'd21);
    rd(4'h5); chk(v & 16'h0002, 16'h0002);
    wr(4'h0, 16'h1104); wr(4'h1, 16'h0020); wr(4'h2, 16'h0005); wr(4'h0, 16'h1114);
    run(20); chk(edges, 16'h0000);
  endtask
  task automatic t_pwm();
    wr(4'h0, 16'h0005); wr(4'h2, 16'h1240); rd(4'h6); chk(v, 16'h0040);
    wr(4'h1, 16'h0000); wr(4'h0, 16'h1215); repeat (300) @(posedge clk);
    run(512); rng(high_a, 16'd376, 16'd390);
    wr(4'h0, 16'h1315); repeat (300) @(posedge clk);
    run(512); rng(high_a, 16'd124, 16'd136);
  endtask
  task automatic t_m15();
    wr(4'h0, 16'h000f); wr(4'h1, 16'h0000); wr(4'h2, 16'h0003); wr(4'h0, 16'h111f);
    repeat (100) @(posedge clk); wr(4'h5, 16'h000f);
    run(80); rng(edges, 16'd19, 16'd21);
    wr(4'h0, 16'h100f); rd(4'h5); chk(v & 16'h0003, 16'h0003);
    @(posedge clk); svc <= 2'h1;
    @(posedge clk); svc <= 2'h0;
    rd(4'h5); chk(v & 16'h0003, 16'h0001);
    rd(4'h9); chk(v, 16'h0000);
  endtask
  task automatic t_cap();
    wr(4'h0, 16'h0000); wr(4'h2, 16'h0007); wr(4'h1, 16'h0007); wr(4'h5, 16'h000f);
    wr(4'h0, 16'h0010); repeat (3) @(posedge clk); wr(4'h0, 16'h0000);
    rd(4'h5); chk(v & 16'h0002, 16'h0000);
    wr(4'h4, 16'h0004); wr(4'h1, 16'h0000); wr(4'h5, 16'h000f);
    wr(4'h0, 16'h001c); repeat (20) @(posedge clk); wr(4'h0, 16'h0000);
    rd(4'h5); chk(v & 16'h0009, 16'h0008);
    rd(4'h1); rng(v, 16'h0000, 16'h0004);
  endtask
  // ----------------------------------------
  // sequence and verdict
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_normal();
    t_presc();
    t_ctc();
    t_pwm();
    t_m15();
    t_cap();
    final_report();
  end
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule // timer16_mode_sequencer_tb
`default_nettype wire
